// File: hdl/ncd_pkg.sv
// Constants of the nonvolatile command dispatcher and read arbiter.
// Assumes a single 125 MHz bus clock and a plain register port.
package ncd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] NCD_OFS_CLKDIV = 8'h00; // Flash clock divider
  localparam logic [7:0] NCD_OFS_CMD = 8'h04;    // Command code and target
  localparam logic [7:0] NCD_OFS_ADDR = 8'h08;   // Start address
  localparam logic [7:0] NCD_OFS_CNT = 8'h0C;    // Count or margin level
  localparam logic [7:0] NCD_OFS_STAT = 8'h10;   // Flash status
  localparam logic [7:0] NCD_OFS_PROT = 8'h14;   // Protection bits
  localparam logic [7:0] NCD_OFS_KEYLO = 8'h18;  // Supplied key, low word
  localparam logic [7:0] NCD_OFS_KEYHI = 8'h1C;  // Supplied key, high word
  localparam logic [7:0] NCD_OFS_MODE = 8'h20;   // Margin and security view

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int NCD_CMD_TGT_BIT = 8;   // 1 selects the EEPROM block
  localparam int NCD_ST_COMMAND_COMPLETE_FLAG = 7;       // Command complete
  localparam int NCD_ST_ACCESS_ERROR_FLAG = 5;     // Access error
  localparam int NCD_ST_PVIOL = 4;      // Protection violation
  localparam int NCD_ST_VFAIL = 1;      // Blank check failed
  localparam int NCD_PR_LOWDIS = 0;     // Program flash low disable
  localparam int NCD_PR_HIGHDIS = 1;    // Program flash high disable
  localparam int NCD_PR_POPEN = 2;      // Program flash open
  localparam int NCD_PR_EOPEN = 3;      // EEPROM open
  localparam logic [3:0] NCD_PROT_RST = 4'h0;
  localparam logic [15:0] NCD_CNT_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0] NCD_C_VFY_ALL = 8'h01;
  localparam logic [7:0] NCD_C_VFY_BLK = 8'h02;
  localparam logic [7:0] NCD_C_VFY_PSEC = 8'h03;
  localparam logic [7:0] NCD_C_RD_ONCE = 8'h04;
  localparam logic [7:0] NCD_C_PRG_P = 8'h06;
  localparam logic [7:0] NCD_C_PRG_ONCE = 8'h07;
  localparam logic [7:0] NCD_C_ERS_ALL = 8'h08;
  localparam logic [7:0] NCD_C_ERS_BLK = 8'h09;
  localparam logic [7:0] NCD_C_ERS_PSEC = 8'h0A;
  localparam logic [7:0] NCD_C_UNSEC = 8'h0B;
  localparam logic [7:0] NCD_C_BACKDOOR = 8'h0C;
  localparam logic [7:0] NCD_C_USR_MRG = 8'h0D;
  localparam logic [7:0] NCD_C_FLD_MRG = 8'h0E;
  localparam logic [7:0] NCD_C_VFY_ESEC = 8'h10;
  localparam logic [7:0] NCD_C_PRG_E = 8'h11;
  localparam logic [7:0] NCD_C_ERS_ESEC = 8'h12;
  localparam logic [7:0] NCD_C_PROT_OVR = 8'h13;
  localparam logic [15:0] NCD_EE_MAX_WORDS = 16'h0004;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: reads stay legal during this lead-in after launch
  localparam int NCD_CLK_PERIOD_NS = 8;
  localparam int NCD_ARM_NS = 40;
  localparam int NCD_ARM_CYCLES =
    (NCD_ARM_NS + NCD_CLK_PERIOD_NS - 1) / NCD_CLK_PERIOD_NS;

  // Sequencer states
  typedef enum logic [1:0] {NCD_IDLE, NCD_ARM, NCD_RUN} ncd_state_t;

endpackage

// File: hdl/ncd_dispatch.sv
// Command dispatcher and read arbiter of a two-array nonvolatile memory.
// Assumes reads and commands are synchronous to clk_sys and that the
// array engine answers each arr_start with one arr_done pulse.
//
// Functional notes
// - 0x01 verifies all blocks erased
// - 0x02 verifies one selected block erased
// - 0x03/0x10 verify counted words from address
// - 0x04 reads the 64-byte once field
// - 0x06 programs one program-flash phrase
// - 0x07 programs once field, once per location
// - 0x08 erases all, needs all open bits
// - 0x09 flash block needs three flash bits
// - 0x09 EEPROM block needs EEPROM open bit
// - 0x0A erases one program-flash sector
// - 0x0B erases all then verifies, unsecures
// - 0x0C unsecures on matching key
// - 0x0D sets user margin per target
// - 0x0E field margin, special mode only
// - 0x11 programs one to four EEPROM words
// - 0x12 erases one EEPROM sector
// - 0x13 overrides protection after key check
// - only listed concurrent pairs are allowed
// - forbidden collision flags illegal access
// - reads succeed before array operation starts
// - illegal access only in collision cycle
// - one read at a time, arbitrated
// - non-normal margin makes reads margin reads
// - write-one to complete flag launches command
// - no divider write blocks program/erase
// - unknown command code sets access error
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps

module ncd_dispatch
  import ncd_pkg::*;
#(
  parameter int ARM_CYCLES = NCD_ARM_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic special_mode,
  input wire logic [63:0] stored_backdoor_key,
  input wire logic [31:0] stored_override_key,
  input wire logic pf_rd_req,
  input wire logic ee_rd_req,
  output logic pf_rd_grant,
  output logic ee_rd_grant,
  output logic illegal_access,
  output logic arr_start,
  output logic [7:0] arr_code,
  output logic arr_pf,
  output logic arr_ee,
  output logic [23:0] arr_addr,
  output logic [15:0] arr_count,
  input wire logic arr_done,
  input wire logic arr_fail,
  output logic security_released,
  output logic pf_margin_active,
  output logic ee_margin_active
);

  // Refuse a lead-in the counter cannot hold
  if (ARM_CYCLES < 1 || ARM_CYCLES > 255)
  begin : g_bad_arm
    $error("ARM_CYCLES must lie in 1..255");
  end

  // Every check below runs on the bus clock and sleeps through reset
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Known command codes
  function automatic logic cmd_known(input logic [7:0] c);
    cmd_known = (c >= NCD_C_VFY_ALL && c <= NCD_C_FLD_MRG && c != 8'h05) ||
      (c >= NCD_C_VFY_ESEC && c <= NCD_C_PROT_OVR);
  endfunction

  // Commands that program or erase cells
  function automatic logic cmd_writes(input logic [7:0] c);
    cmd_writes = c == NCD_C_PRG_P || c == NCD_C_PRG_ONCE ||
      c == NCD_C_ERS_ALL || c == NCD_C_ERS_BLK || c == NCD_C_ERS_PSEC ||
      c == NCD_C_UNSEC || c == NCD_C_PRG_E || c == NCD_C_ERS_ESEC;
  endfunction

  // Arrays occupied by a command, {pflash, eeprom}; zero for register-only
  function automatic logic [1:0] cmd_arrays(input logic [7:0] c,
                                            input logic ee);
    unique case (c)
      NCD_C_VFY_ALL, NCD_C_ERS_ALL, NCD_C_UNSEC: cmd_arrays = 2'b11;
      NCD_C_VFY_BLK, NCD_C_ERS_BLK: cmd_arrays = ee ? 2'b01 : 2'b10;
      NCD_C_VFY_PSEC, NCD_C_RD_ONCE, NCD_C_PRG_P, NCD_C_PRG_ONCE,
      NCD_C_ERS_PSEC: cmd_arrays = 2'b10;
      NCD_C_VFY_ESEC, NCD_C_PRG_E, NCD_C_ERS_ESEC: cmd_arrays = 2'b01;
      default: cmd_arrays = 2'b00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  ncd_state_t state_q; // Sequencer
  logic div_loaded_q; // Divider written since reset
  logic [15:0] clkdiv_q; // Divider value, kept for software
  logic [8:0] cmd_q; // Code plus target bit
  logic [23:0] addr_q; // Start address
  logic [15:0] cnt_q; // Word count or margin level
  logic [3:0] prot_q; // Protection bits
  logic [63:0] key_q; // Supplied key
  logic command_complete_flag_q; // Command complete
  logic access_error_flag_q; // Access error
  logic pviol_q; // Protection violation
  logic vfail_q; // Blank check failed
  logic [7:0] arm_q; // Lead-in counter
  logic verify_phase_q; // Unsecure sequence in its verify step
  logic [7:0] once_done_q; // One bit per 8-byte phrase of once field
  logic override_q; // Protection temporarily overridden
  logic secure_off_q; // Security released
  logic pf_margin_q; // Program flash margin not normal
  logic ee_margin_q; // EEPROM margin not normal
  logic [31:0] rdata_q; // Read data, one cycle after strobe

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  wire wr_cmd = bus_wr && command_complete_flag_q; // Parameters frozen while busy
  wire wr_div = bus_wr && bus_addr == NCD_OFS_CLKDIV;
  wire wr_stat = bus_wr && bus_addr == NCD_OFS_STAT;
  wire [7:0] code = cmd_q[7:0];
  wire tgt_ee = cmd_q[NCD_CMD_TGT_BIT];
  wire [1:0] arrays = cmd_arrays(code, tgt_ee);
  wire [3:0] prot_eff = prot_q | {4{override_q}};
  wire flash_open = prot_eff[NCD_PR_LOWDIS] && prot_eff[NCD_PR_HIGHDIS] &&
    prot_eff[NCD_PR_POPEN];
  wire ee_open = prot_eff[NCD_PR_EOPEN];

  // Launch: write one to the complete flag while it is set
  wire launch = wr_stat && bus_wdata[NCD_ST_COMMAND_COMPLETE_FLAG] && command_complete_flag_q &&
    !access_error_flag_q && !pviol_q;

  // Launch refusals raising the access error
  wire bad_code = !cmd_known(code);
  wire bad_div = cmd_writes(code) && !div_loaded_q;
  wire bad_mode = code == NCD_C_FLD_MRG && !special_mode;
  wire bad_count = code == NCD_C_PRG_E &&
    (cnt_q == 16'h0000 || cnt_q > NCD_EE_MAX_WORDS);
  wire bad_once = code == NCD_C_PRG_ONCE && once_done_q[addr_q[2:0]];
  wire acc_fail = bad_code || bad_div || bad_mode || bad_count || bad_once;

  // Erase protection checks
  wire prot_fail =
    (code == NCD_C_ERS_ALL && !(flash_open && ee_open)) ||
    (code == NCD_C_ERS_BLK && !tgt_ee && !flash_open) ||
    (code == NCD_C_ERS_BLK && tgt_ee && !ee_open);
  wire go = launch && !acc_fail && !prot_fail;

  // Key checks
  wire key_ok = key_q == stored_backdoor_key;
  wire ovr_ok = key_q[31:0] == stored_override_key;
  wire arm_end = state_q == NCD_ARM && arm_q == 8'h01;
  wire run_end = state_q == NCD_RUN && arr_done;
  wire unsec_next = run_end && code == NCD_C_UNSEC && !verify_phase_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read arbitration; busy only once the array operation has begun

  wire pf_busy = state_q == NCD_RUN && arrays[1];
  wire ee_busy = state_q == NCD_RUN && arrays[0];
  // Program flash read is forbidden against own-array work, and as a
  // margin read against any EEPROM activity or read
  wire pf_bad = pf_busy || (pf_margin_q && (ee_busy || ee_rd_req));
  // EEPROM read is forbidden while either array is working
  wire ee_bad = ee_busy || pf_busy;
  wire pf_ok = pf_rd_req && !pf_bad;
  wire ee_ok = ee_rd_req && !ee_bad;

  // Flagged in the colliding cycle only
  assign illegal_access = (pf_rd_req && pf_bad) ||
    (ee_rd_req && ee_bad);
  // One read per cycle; program flash first, EEPROM holds its request
  assign pf_rd_grant = pf_ok;
  assign ee_rd_grant = ee_ok && !pf_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  wire [31:0] stat_word = 32'h0000_0000 |
    (32'(command_complete_flag_q) << NCD_ST_COMMAND_COMPLETE_FLAG) | (32'(access_error_flag_q) << NCD_ST_ACCESS_ERROR_FLAG) |
    (32'(pviol_q) << NCD_ST_PVIOL) | (32'(vfail_q) << NCD_ST_VFAIL);
  wire [31:0] mode_word = {26'h000_0000, override_q, secure_off_q,
    ee_margin_q, pf_margin_q, div_loaded_q, special_mode};
  logic [31:0] rd_mux;

  // Unmapped offsets read as zero
  always_comb
  begin
    unique case (bus_addr)
      NCD_OFS_CLKDIV: rd_mux = {16'h0000, clkdiv_q};
      NCD_OFS_CMD: rd_mux = {23'h00_0000, cmd_q};
      NCD_OFS_ADDR: rd_mux = {8'h00, addr_q};
      NCD_OFS_CNT: rd_mux = {16'h0000, cnt_q};
      NCD_OFS_STAT: rd_mux = stat_word;
      NCD_OFS_PROT: rd_mux = {28'h000_0000, prot_q};
      NCD_OFS_KEYLO: rd_mux = key_q[31:0];
      NCD_OFS_KEYHI: rd_mux = key_q[63:32];
      NCD_OFS_MODE: rd_mux = mode_word;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (!resetn || !bus_rd)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rd_mux;
  end
  assign bus_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers; command parameters ignored while busy

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      clkdiv_q <= 16'h0000;
      div_loaded_q <= 1'b0;
      cmd_q <= 9'h000;
      addr_q <= 24'h00_0000;
      cnt_q <= NCD_CNT_RST;
      prot_q <= NCD_PROT_RST;
      key_q <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      if (wr_div)
      begin
        clkdiv_q <= bus_wdata[15:0];
        div_loaded_q <= 1'b1;
      end
      if (wr_cmd && bus_addr == NCD_OFS_CMD)
        cmd_q <= bus_wdata[8:0];
      if (wr_cmd && bus_addr == NCD_OFS_ADDR)
        addr_q <= bus_wdata[23:0];
      if (wr_cmd && bus_addr == NCD_OFS_CNT)
        cnt_q <= bus_wdata[15:0];
      if (wr_cmd && bus_addr == NCD_OFS_PROT)
        prot_q <= bus_wdata[3:0];
      if (wr_cmd && bus_addr == NCD_OFS_KEYLO)
        key_q[31:0] <= bus_wdata;
      if (wr_cmd && bus_addr == NCD_OFS_KEYHI)
        key_q[63:32] <= bus_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: a hardware set wins over a software clear

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      access_error_flag_q <= 1'b0;
      pviol_q <= 1'b0;
      vfail_q <= 1'b0;
    end
    else
    begin
      if (launch && acc_fail)
        access_error_flag_q <= 1'b1;
      else if (wr_stat && bus_wdata[NCD_ST_ACCESS_ERROR_FLAG])
        access_error_flag_q <= 1'b0;
      if (launch && !acc_fail && prot_fail)
        pviol_q <= 1'b1;
      else if (wr_stat && bus_wdata[NCD_ST_PVIOL])
        pviol_q <= 1'b0;
      if (run_end && arr_fail)
        vfail_q <= 1'b1;
      else if (go)
        vfail_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: lead-in, then array run until done

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      state_q <= NCD_IDLE;
      command_complete_flag_q <= 1'b1;
      arm_q <= 8'h00;
      verify_phase_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        NCD_IDLE:
          if (go)
          begin
            command_complete_flag_q <= 1'b0;
            arm_q <= 8'(ARM_CYCLES);
            state_q <= NCD_ARM;
          end
        NCD_ARM:
          if (arm_end)
          begin
            // Register-only commands finish without the array
            if (arrays == 2'b00)
            begin
              command_complete_flag_q <= 1'b1;
              state_q <= NCD_IDLE;
            end
            else
              state_q <= NCD_RUN;
          end
          else
            arm_q <= arm_q - 8'h01;
        NCD_RUN:
          if (unsec_next)
            verify_phase_q <= 1'b1;
          else if (run_end)
          begin
            verify_phase_q <= 1'b0;
            command_complete_flag_q <= 1'b1;
            state_q <= NCD_IDLE;
          end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array request: one pulse per array step

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      arr_start <= 1'b0;
      arr_code <= 8'h00;
      arr_pf <= 1'b0;
      arr_ee <= 1'b0;
      arr_addr <= 24'h00_0000;
      arr_count <= 16'h0000;
    end
    else
    begin
      arr_start <= (arm_end && arrays != 2'b00) || unsec_next;
      if (arm_end)
      begin
        // Verify, read-once, program and erase steps
        arr_code <= code;
        arr_pf <= arrays[1];
        arr_ee <= arrays[0];
        arr_addr <= addr_q;
        arr_count <= cnt_q;
      end
      else if (unsec_next)
        arr_code <= NCD_C_VFY_ALL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode state: once field, security, override, margins

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      once_done_q <= 8'h00;
      secure_off_q <= 1'b0;
      override_q <= 1'b0;
      pf_margin_q <= 1'b0;
      ee_margin_q <= 1'b0;
    end
    else
    begin
      if (run_end && code == NCD_C_PRG_ONCE)
        once_done_q[addr_q[2:0]] <= 1'b1;
      // A clean verify step after the erase step, or a matching backdoor key, releases security
      if (run_end && code == NCD_C_UNSEC && verify_phase_q && !arr_fail)
        secure_off_q <= 1'b1;
      if (arm_end && code == NCD_C_BACKDOOR && key_ok)
        secure_off_q <= 1'b1;
      if (arm_end && code == NCD_C_PROT_OVR)
        override_q <= ovr_ok;
      if (arm_end && (code == NCD_C_USR_MRG || code == NCD_C_FLD_MRG))
      begin
        if (tgt_ee)
          ee_margin_q <= cnt_q != 16'h0000;
        else
          pf_margin_q <= cnt_q != 16'h0000;
      end
    end
  end

  assign security_released = secure_off_q;
  assign pf_margin_active = pf_margin_q;
  assign ee_margin_active = ee_margin_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  launch_busy_a: assert property (go |=> !command_complete_flag_q && state_q == NCD_ARM)
    else $error("launch did not clear complete flag");

  done_command_complete_flag_a: assert property (run_end && !unsec_next |=>
    command_complete_flag_q && state_q == NCD_IDLE)
    else $error("completion did not set complete flag");

  no_div_a: assert property (launch && cmd_writes(code) &&
    !div_loaded_q |=> access_error_flag_q && command_complete_flag_q)
    else $error("program without divider was not refused");

  bad_code_a: assert property (launch && !cmd_known(code) |=>
    access_error_flag_q && state_q == NCD_IDLE)
    else $error("unknown code not flagged");

  erase_prot_a: assert property (launch && code == NCD_C_ERS_BLK &&
    tgt_ee && !ee_open && !acc_fail |=> pviol_q && command_complete_flag_q)
    else $error("closed EEPROM block erase not refused");

  all_prot_a: assert property (launch && code == NCD_C_ERS_ALL &&
    !(flash_open && ee_open) && !acc_fail |=> pviol_q)
    else $error("closed erase all not refused");

  arm_read_a: assert property (state_q == NCD_ARM |-> !illegal_access ||
    (pf_margin_q && pf_rd_req && ee_rd_req))
    else $error("read refused during lead-in");

  arr_kick_a: assert property (go && arrays != 2'b00 |->
    ##(ARM_CYCLES + 1) arr_start)
    else $error("array start not issued after lead-in");

  collide_a: assert property (pf_busy && ee_rd_req |->
    illegal_access && !ee_rd_grant)
    else $error("forbidden EEPROM read not flagged");

  one_read_a: assert property (!(pf_rd_grant && ee_rd_grant) &&
    !(illegal_access && !pf_rd_req && !ee_rd_req))
    else $error("two grants or idle illegal flag");

  pf_over_ee_a: assert property (ee_busy && !pf_busy && pf_rd_req &&
    !pf_margin_q |-> pf_rd_grant && illegal_access == ee_rd_req)
    else $error("flash read blocked by EEPROM work");

  once_lock_a: assert property (launch && code == NCD_C_PRG_ONCE &&
    once_done_q[addr_q[2:0]] |=> access_error_flag_q && command_complete_flag_q)
    else $error("once field reprogram accepted");

  eeprog_cnt_a: assert property (launch && code == NCD_C_PRG_E &&
    cnt_q > NCD_EE_MAX_WORDS |=> access_error_flag_q)
    else $error("oversize EEPROM program accepted");

  field_mode_a: assert property (launch && code == NCD_C_FLD_MRG &&
    !special_mode |=> access_error_flag_q)
    else $error("field margin outside special mode");

endmodule

// File: testbench/ncd_array_model.sv
// Array engine model: each step start gives one done pulse later.
// Assumes the dispatcher's step outputs are registered on clk_sys.
`timescale 1ns/100ps
module ncd_array_model
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic arr_start,
  input wire logic [7:0] lat,
  input wire logic fail_req,
  output logic arr_done,
  output logic arr_fail
);
  logic [7:0] cnt_q; // Busy cycles left, zero when idle
  ////////////////////////////////////////////////////////////////////////////
  // Busy counter; fail toggles outside done so nobody may lean on it
  always @(posedge clk_sys)
  begin
    arr_done <= 1'b0;
    arr_fail <= ~arr_fail;
    if (!resetn)
    begin
      cnt_q <= 8'h00;
      arr_fail <= 1'b0;
    end
    else if (arr_start)
      cnt_q <= lat + 8'h01;
    else if (cnt_q == 8'h01)
    begin
      cnt_q <= 8'h00;
      arr_done <= 1'b1;
      arr_fail <= fail_req;
    end
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
endmodule

// File: testbench/tb.sv
// Bench for the command dispatcher: register tasks and read probes.
// Assumes ncd_pkg and the array model on the step interface.
`timescale 1ns/100ps
module tb;
  import ncd_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0000_0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic special_mode = 1'b0;
  logic pf_rd_req = 1'b0;
  logic ee_rd_req = 1'b0;
  logic fail_req = 1'b0; // Model reports a blank check failure
  logic [7:0] lat = 8'h10; // Model busy time, long enough to probe
  logic [31:0] bus_rdata, rd_q;
  logic [7:0] arr_code;
  logic [23:0] arr_addr;
  logic [15:0] arr_count;
  logic pf_rd_grant, ee_rd_grant, illegal_access, arr_start, arr_pf;
  logic arr_ee, arr_done, arr_fail, security_released, ill_seen;
  logic pf_margin_active, ee_margin_active;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_wait;
  localparam logic [63:0] BD_KEY = 64'h0123_4567_89ab_cdef; // Arbitrary
  localparam logic [31:0] OV_KEY = 32'h5a5a_c3c3; // Arbitrary
  // Array commands {target, code} and the arrays each must use
  logic [8:0] tcmd [10] = '{9'h001, 9'h002, 9'h003, 9'h004, 9'h006,
    9'h007, 9'h00a, 9'h110, 9'h111, 9'h112};
  logic [1:0] tuse [10] = '{2'h3, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
    2'h1, 2'h1, 2'h1};
  always #4 clk_sys = ~clk_sys;
  ncd_dispatch ncd_dispatch_i (
    .stored_backdoor_key(BD_KEY), .stored_override_key(OV_KEY), .*);
  ncd_array_model ncd_array_model_i (.*);
  ////////////////////////////////////////////////////////////////////////////
  // Compare and bus tasks
  task automatic chk(input string nm, input logic [31:0] got,
    input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe is taken
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1 rd_q = bus_rdata;
  endtask
  task automatic launch(input logic [8:0] c);
    wr(NCD_OFS_CMD, {23'h0, c});
    wr(NCD_OFS_STAT, 32'h0000_0080);
  endtask
  // Bounded wait for a step start; notes any illegal flag meanwhile
  task automatic await_start(input logic [7:0] code);
    n_wait = 0;
    ill_seen = 1'b0;
    do
    begin
      @(posedge clk_sys);
      #1 n_wait++;
      ill_seen = ill_seen | (illegal_access & ~arr_start);
    end while (arr_start !== 1'b1 && n_wait < 60);
    chk("arr_code", arr_code, code);
  endtask
  task automatic step(input logic [8:0] c);
    launch(c);
    await_start(c[7:0]);
    chk("lead_in", n_wait, NCD_ARM_CYCLES);
    chk("lead_ill", ill_seen, 1'b0);
  endtask
  task automatic wait_idle(input logic [31:0] exp);
    for (int i = 0; i < 60; i++)
    begin
      rd(NCD_OFS_STAT);
      if (rd_q[7] === 1'b1)
        break;
    end
    chk("status", rd_q, exp);
  endtask
  // Drive both read requests and look at grants and illegal flag
  task automatic probe(input logic p, input logic e, input logic [2:0] x);
    @(posedge clk_sys);
    pf_rd_req <= p;
    ee_rd_req <= e;
    #1 chk("reads", {pf_rd_grant, ee_rd_grant, illegal_access}, x);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog at 12500 cycles, far beyond the few hundred cycles the tests need
  initial
  begin
    #100000;
    n_mismatch++;
    summarize;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(NCD_OFS_STAT);
    chk("stat_rst", rd_q, 32'h0000_0080);
    rd(NCD_OFS_MODE);
    chk("mode_rst", rd_q, 32'h0000_0000);
    rd(8'h3c);
    chk("unmapped", rd_q, 32'h0000_0000);
    probe(1'b1, 1'b1, 3'h4);
    probe(1'b0, 1'b1, 3'h2);
    probe(1'b0, 1'b0, 3'h0);
    $display("test reset done");
    // Program before divider write, then an unknown code
    launch({1'b0, NCD_C_PRG_P});
    rd(NCD_OFS_STAT);
    chk("no_div", rd_q, 32'h0000_00a0);
    wr(NCD_OFS_STAT, 32'h0000_0020);
    wr(NCD_OFS_CLKDIV, 32'h0000_0013);
    launch(9'h005);
    rd(NCD_OFS_STAT);
    chk("bad_code", rd_q, 32'h0000_00a0);
    wr(NCD_OFS_STAT, 32'h0000_0020);
    $display("test access errors done");
    // Erase all: one protection bit short, then all open
    wr(NCD_OFS_PROT, 32'h0000_0007);
    launch({1'b0, NCD_C_ERS_ALL});
    rd(NCD_OFS_STAT);
    chk("ers_all_prot", rd_q, 32'h0000_0090);
    wr(NCD_OFS_STAT, 32'h0000_0010);
    wr(NCD_OFS_PROT, 32'h0000_000f);
    probe(1'b1, 1'b0, 3'h4);
    step({1'b0, NCD_C_ERS_ALL});
    chk("ers_all_arr", {arr_pf, arr_ee}, 2'h3);
    probe(1'b1, 1'b0, 3'h1);
    probe(1'b0, 1'b0, 3'h0);
    wait_idle(32'h0000_0080);
    step({1'b0, NCD_C_UNSEC});
    await_start(NCD_C_VFY_ALL);
    wait_idle(32'h0000_0080);
    chk("unsec", security_released, 1'b1);
    $display("test mass erase done");
    // Block erase with only the EEPROM open bit, then override
    wr(NCD_OFS_PROT, 32'h0000_0007);
    launch({1'b1, NCD_C_ERS_BLK});
    rd(NCD_OFS_STAT);
    chk("ee_blk_prot", rd_q, 32'h0000_0090);
    wr(NCD_OFS_STAT, 32'h0000_0010);
    wr(NCD_OFS_PROT, 32'h0000_0008);
    step({1'b1, NCD_C_ERS_BLK});
    chk("ee_blk_arr", {arr_pf, arr_ee}, 2'h1);
    wait_idle(32'h0000_0080);
    launch({1'b0, NCD_C_ERS_BLK});
    rd(NCD_OFS_STAT);
    chk("pf_blk_prot", rd_q, 32'h0000_0090);
    wr(NCD_OFS_STAT, 32'h0000_0010);
    wr(NCD_OFS_KEYLO, OV_KEY);
    launch({1'b0, NCD_C_PROT_OVR});
    wait_idle(32'h0000_0080);
    rd(NCD_OFS_MODE);
    chk("override", rd_q, 32'h0000_0032);
    step({1'b0, NCD_C_ERS_BLK});
    wait_idle(32'h0000_0080);
    $display("test protection done");
    // The array commands of tcmd, prompt answers, first one failing
    lat <= 8'h00;
    wr(NCD_OFS_CNT, 32'h0000_0004);
    wr(NCD_OFS_ADDR, 32'h0000_0108);
    for (int k = 0; k < 10; k++)
    begin
      fail_req <= (k == 0);
      step(tcmd[k]);
      chk("arrays", {arr_pf, arr_ee}, tuse[k]);
      chk("addr_cnt", {arr_addr[15:0], arr_count}, 32'h0108_0004);
      wait_idle((k == 0) ? 32'h0000_0082 : 32'h0000_0080);
    end
    launch({1'b0, NCD_C_PRG_ONCE});
    rd(NCD_OFS_STAT);
    chk("once_again", rd_q[7] & (rd_q[5] | rd_q[4]), 1'b1);
    wr(NCD_OFS_STAT, 32'h0000_0030);
    wr(NCD_OFS_CNT, 32'h0000_0005);
    launch({1'b1, NCD_C_PRG_E});
    rd(NCD_OFS_STAT);
    chk("ee_cnt5", rd_q, 32'h0000_00a0);
    wr(NCD_OFS_STAT, 32'h0000_0020);
    $display("test command table done");
    // Flash read beside an EEPROM program
    lat <= 8'h10;
    wr(NCD_OFS_CNT, 32'h0000_0002);
    step({1'b1, NCD_C_PRG_E});
    probe(1'b1, 1'b0, 3'h4);
    probe(1'b0, 1'b1, 3'h1);
    probe(1'b0, 1'b0, 3'h0);
    wait_idle(32'h0000_0080);
    $display("test concurrency done");
    // Margin levels
    wr(NCD_OFS_CNT, 32'h0000_0001);
    launch({1'b0, NCD_C_FLD_MRG});
    rd(NCD_OFS_STAT);
    chk("fld_normal", rd_q, 32'h0000_00a0);
    wr(NCD_OFS_STAT, 32'h0000_0020);
    @(posedge clk_sys);
    special_mode <= 1'b1;
    launch({1'b0, NCD_C_FLD_MRG});
    wait_idle(32'h0000_0080);
    chk("pf_margin", pf_margin_active, 1'b1);
    @(posedge clk_sys);
    pf_rd_req <= 1'b1;
    ee_rd_req <= 1'b1;
    #1 chk("margin_rd", illegal_access, 1'b1);
    probe(1'b0, 1'b0, 3'h0);
    launch({1'b1, NCD_C_USR_MRG});
    wait_idle(32'h0000_0080);
    chk("ee_margin", ee_margin_active, 1'b1);
    $display("test margin done");
    // Reset while idle, then the backdoor key
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    #1 chk("sec_rst", security_released, 1'b0);
    wr(NCD_OFS_KEYLO, BD_KEY[31:0]);
    wr(NCD_OFS_KEYHI, BD_KEY[63:32]);
    launch({1'b0, NCD_C_BACKDOOR});
    wait_idle(32'h0000_0080);
    chk("backdoor", security_released, 1'b1);
    $display("test backdoor done");
    summarize;
  end
endmodule
